// >>> src/peripheral_dma_channel_regs.v
// Function
// [R1] Rx count zero halts, nonzero runs if enabled
// [R2] Tx count zero halts, nonzero runs if enabled
// [R3] Software loads rx count with buffer size
// [R4] Software loads tx address with buffer start
// [R5] Software loads tx count with buffer size
// [R6] Half duplex: current addresses shared
// [R7] Half duplex: current counts shared
// [R8] Half duplex: next addresses shared
// [R9] Half duplex: next counts shared
// [R10] Next receive buffer address register
// [R11] Next receive buffer size register
// [R12] Next transmit buffer address register
// [R13] Next transmit buffer size register
// [R14] Bit 0 enables rx unless bit 1
// [R15] Bit 1 disables rx requests
// [R16] Bit 8 enables tx requests
// [R17] Bit 9 disables tx requests
// [R18] Half duplex: rx enable disables tx
// [R19] Half duplex: rx disable disables tx
// [R20] Half duplex: tx enable only without rx
// [R21] Half duplex: tx disable disables rx
// [R22] Software never sets both enables half duplex
// [R23] Count zero: reload from next or stop
// [R24] Address advances by 1, 2 or 4
// [R25] State register shows enables per direction
// [R26] Reserved bits and control read zero
// [R27] Enable change acts at write completion
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`include "periph_dma_defines.vh"

module peripheral_dma_channel_regs (
    input wire hclk, // System clock
    input wire hresetn, // Async reset, active low
    input wire hsel, // Slave select
    input wire [31:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write when high
    input wire [2:0] hsize, // Transfer size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready
    output reg hreadyout, // Slave ready
    output reg [31:0] hrdata, // Read data
    output reg hresp, // Always OKAY
    input wire half_duplex, // Peripheral is half duplex
    input wire [1:0] unit_size, // Byte, half or word units
    input wire rx_ready, // Peripheral has rx data
    input wire [31:0] rx_hold_data, // Peripheral rx holding data
    input wire tx_ready, // Peripheral wants tx data
    output reg rx_take, // Rx data taken, pulse
    output reg [31:0] tx_hold_data, // Data for peripheral
    output reg tx_load, // Tx data valid, pulse
    output reg mem_req, // Memory access request
    output reg mem_write, // Memory write when high
    output reg [31:0] mem_addr, // Memory byte address
    output reg [1:0] mem_size, // Memory access size
    output reg [31:0] mem_wdata, // Memory write data
    input wire mem_ack, // Memory access done
    input wire [31:0] mem_rdata, // Memory read data
    output reg rx_active, // Rx requests enabled
    output reg tx_active // Tx requests enabled
);

    // Engine states, one-hot
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_RX = 4'b0010;
    localparam [3:0] ST_TX = 4'b0100;
    localparam [3:0] ST_SETTLE = 4'b1000;

    // Current and next buffers, per direction
    reg [31:0] rx_address_field_q;
    reg [`COUNT_W-1:0] rx_count_field_q;
    reg [31:0] tx_address_field_q;
    reg [`COUNT_W-1:0] tx_count_field_q;
    reg [31:0] rx_next_address_field_q;
    reg [`COUNT_W-1:0] rx_next_count_field_q;
    reg [31:0] tx_next_address_field_q;
    reg [`COUNT_W-1:0] tx_next_count_field_q;

    // Engine state and bus data phase
    reg [3:0] state_q;
    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] addr_q;

    // Combinational helpers
    reg [31:0] rd_mux;
    reg [31:0] eng_ptr;
    reg [`COUNT_W-1:0] eng_cnt;
    reg [`COUNT_W-1:0] eng_dec;
    reg [31:0] eng_nptr;
    reg [`COUNT_W-1:0] eng_ncnt;
    reg [31:0] eng_inc;

    // Next values of the enable flops
    reg rx_en_d;
    reg tx_en_d;

    // Address phase accepted at this edge
    wire addr_phase = hsel & htrans[1] & hready;

    // Decode of the pending data phase
    wire mapped = (addr_q <= `OFS_TRANSFER_STATE) && (addr_q[1:0] == 2'h0);
    wire wr_ctl = wr_pend_q && (addr_q == `OFS_TRANSFER_CONTROL);

    // Unit may start: enabled, count left, ready
    wire rx_go = rx_active && (rx_count_field_q != `RST_COUNT) && rx_ready;
    wire tx_go = tx_active && (tx_count_field_q != `RST_COUNT) && tx_ready;

    // Unit done; half duplex moves both copies
    wire adv = mem_ack && ((state_q == ST_RX) || (state_q == ST_TX));
    wire adv_rx = adv && ((state_q == ST_RX) || half_duplex);
    wire adv_tx = adv && ((state_q == ST_TX) || half_duplex);

    // Read data mux; control reads zero
    always @* begin
        rd_mux = 32'h0000_0000;
        if (mapped) begin
            case (addr_q)
                `OFS_RX_ADDRESS: rd_mux = rx_address_field_q;
                // Counts fill 15:0, upper bits read zero
                `OFS_RX_COUNT: rd_mux = {16'h0000, rx_count_field_q}; // see [R26]
                `OFS_TX_ADDRESS: rd_mux = tx_address_field_q;
                `OFS_TX_COUNT: rd_mux = {16'h0000, tx_count_field_q};
                `OFS_RX_NEXT_ADDRESS: rd_mux = rx_next_address_field_q;
                `OFS_RX_NEXT_COUNT: rd_mux = {16'h0000, rx_next_count_field_q};
                `OFS_TX_NEXT_ADDRESS: rd_mux = tx_next_address_field_q;
                `OFS_TX_NEXT_COUNT: rd_mux = {16'h0000, tx_next_count_field_q};
                // Live enable bits, one per direction
                `OFS_TRANSFER_STATE: begin
                    rd_mux[`BIT_RX_REQUEST_ENABLE] = rx_active; // see [R25]
                    rd_mux[`BIT_TX_REQUEST_ENABLE] = tx_active;
                end
                default: rd_mux = 32'h0000_0000; // see [R26]
            endcase
        end
    end

    // Next state of the two enable bits
    always @* begin
        rx_en_d = rx_active;
        tx_en_d = tx_active;
        if (wr_ctl) begin
            // Shared channel: any disable stops both
            if (half_duplex) begin
                if (hwdata[`BIT_RX_REQUEST_DISABLE] || hwdata[`BIT_TX_REQUEST_DISABLE]) begin
                    rx_en_d = 1'b0; // see [R21]
                    tx_en_d = 1'b0; // see [R19]
                end else if (hwdata[`BIT_RX_REQUEST_ENABLE]) begin
                    rx_en_d = 1'b1;
                    tx_en_d = 1'b0; // see [R18]
                end else if (hwdata[`BIT_TX_REQUEST_ENABLE]) begin
                    tx_en_d = 1'b1; // see [R20]
                end
            end else begin
                // Separate channels: disable wins
                if (hwdata[`BIT_RX_REQUEST_DISABLE]) begin
                    rx_en_d = 1'b0; // see [R15]
                end else if (hwdata[`BIT_RX_REQUEST_ENABLE]) begin
                    rx_en_d = 1'b1; // see [R14]
                end
                if (hwdata[`BIT_TX_REQUEST_DISABLE]) begin
                    tx_en_d = 1'b0; // see [R17]
                end else if (hwdata[`BIT_TX_REQUEST_ENABLE]) begin
                    tx_en_d = 1'b1; // see [R16]
                end
            end
        end
    end

    // Pointer and counter step of the active direction
    always @* begin
        // Receive view in ST_RX, transmit otherwise
        if (state_q == ST_RX) begin
            eng_ptr = rx_address_field_q;
            eng_cnt = rx_count_field_q;
            eng_nptr = rx_next_address_field_q;
            eng_ncnt = rx_next_count_field_q;
        end else begin
            eng_ptr = tx_address_field_q;
            eng_cnt = tx_count_field_q;
            eng_nptr = tx_next_address_field_q;
            eng_ncnt = tx_next_count_field_q;
        end
        // Wraps only if a count is zeroed mid-unit
        eng_dec = eng_cnt - 16'h0001;
        // Address step follows the unit size
        case (mem_size)
            `SIZE_BYTE: eng_inc = 32'h0000_0001; // see [R24]
            `SIZE_HALF: eng_inc = 32'h0000_0002;
            default: eng_inc = 32'h0000_0004;
        endcase
    end

    // Bus slave phases: writes zero wait, reads one wait
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            // Every answer is OKAY
            hresp <= 1'b0;
            wr_pend_q <= addr_phase & hwrite;
            rd_pend_q <= addr_phase & ~hwrite;
            // Upper addresses fold onto unmapped offset 0xFC
            if (addr_phase) begin
                addr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFC;
            end
            // One wait per read gives the mux a cycle
            hreadyout <= ~(addr_phase & ~hwrite);
            // Read data holds until the next read
            if (rd_pend_q) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Registers: engine updates, bus writes take priority
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_address_field_q <= `RST_ADDRESS;
            rx_count_field_q <= `RST_COUNT;
            tx_address_field_q <= `RST_ADDRESS;
            tx_count_field_q <= `RST_COUNT;
            rx_next_address_field_q <= `RST_ADDRESS;
            rx_next_count_field_q <= `RST_COUNT;
            tx_next_address_field_q <= `RST_ADDRESS;
            tx_next_count_field_q <= `RST_COUNT;
            rx_active <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            // Enables follow the control write
            rx_active <= rx_en_d; // see [R27]
            tx_active <= tx_en_d;

            // Engine step: advance, or reload at zero
            if (adv_rx) begin
                if (eng_dec == `RST_COUNT && eng_ncnt != `RST_COUNT) begin
                    rx_address_field_q <= eng_nptr; // see [R23]
                    rx_count_field_q <= eng_ncnt;
                    rx_next_address_field_q <= `RST_ADDRESS;
                    rx_next_count_field_q <= `RST_COUNT;
                end else begin
                    rx_address_field_q <= eng_ptr + eng_inc;
                    rx_count_field_q <= eng_dec;
                end
            end

            if (adv_tx) begin
                if (eng_dec == `RST_COUNT && eng_ncnt != `RST_COUNT) begin
                    tx_address_field_q <= eng_nptr; // see [R23]
                    tx_count_field_q <= eng_ncnt;
                    tx_next_address_field_q <= `RST_ADDRESS;
                    tx_next_count_field_q <= `RST_COUNT;
                end else begin
                    tx_address_field_q <= eng_ptr + eng_inc;
                    tx_count_field_q <= eng_dec;
                end
            end

            // Bus write last, so it beats the engine
            if (wr_pend_q) begin
                case (addr_q)
                    `OFS_RX_ADDRESS: begin
                        rx_address_field_q <= hwdata;
                        if (half_duplex) tx_address_field_q <= hwdata; // see [R6]
                    end
                    `OFS_TX_ADDRESS: begin
                        tx_address_field_q <= hwdata;
                        if (half_duplex) rx_address_field_q <= hwdata; // see [R6]
                    end
                    `OFS_RX_COUNT: begin
                        rx_count_field_q <= hwdata[15:0]; // see [R1]
                        if (half_duplex) tx_count_field_q <= hwdata[15:0]; // see [R7]
                    end
                    `OFS_TX_COUNT: begin
                        tx_count_field_q <= hwdata[15:0]; // see [R2]
                        if (half_duplex) rx_count_field_q <= hwdata[15:0]; // see [R7]
                    end
                    `OFS_RX_NEXT_ADDRESS: begin
                        rx_next_address_field_q <= hwdata; // see [R10]
                        if (half_duplex) tx_next_address_field_q <= hwdata; // see [R8]
                    end
                    `OFS_TX_NEXT_ADDRESS: begin
                        tx_next_address_field_q <= hwdata; // see [R12]
                        if (half_duplex) rx_next_address_field_q <= hwdata; // see [R8]
                    end
                    `OFS_RX_NEXT_COUNT: begin
                        rx_next_count_field_q <= hwdata[15:0]; // see [R11]
                        if (half_duplex) tx_next_count_field_q <= hwdata[15:0]; // see [R9]
                    end
                    `OFS_TX_NEXT_COUNT: begin
                        tx_next_count_field_q <= hwdata[15:0]; // see [R13]
                        if (half_duplex) rx_next_count_field_q <= hwdata[15:0]; // see [R9]
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Transfer engine: one unit per peripheral ready
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_size <= `SIZE_BYTE;
            mem_wdata <= 32'h0000_0000;
            rx_take <= 1'b0;
            tx_load <= 1'b0;
            tx_hold_data <= 32'h0000_0000;
        end else begin
            rx_take <= 1'b0;
            tx_load <= 1'b0;
            case (state_q)
                // Receive has priority over transmit
                ST_IDLE: begin
                    if (rx_go) begin // see [R1]
                        mem_req <= 1'b1;
                        mem_write <= 1'b1;
                        mem_addr <= rx_address_field_q;
                        mem_size <= unit_size;
                        mem_wdata <= rx_hold_data;
                        state_q <= ST_RX;
                    end else if (tx_go) begin // see [R2]
                        mem_req <= 1'b1;
                        mem_write <= 1'b0;
                        mem_addr <= tx_address_field_q;
                        mem_size <= unit_size;
                        state_q <= ST_TX;
                    end
                end

                // Memory write done: free rx data
                ST_RX: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        rx_take <= 1'b1;
                        state_q <= ST_SETTLE;
                    end
                end

                // Memory read done: hand data over
                ST_TX: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        tx_hold_data <= mem_rdata;
                        tx_load <= 1'b1;
                        state_q <= ST_SETTLE;
                    end
                end

                // Lets ready fall after the pulse
                ST_SETTLE: begin
                    state_q <= ST_IDLE;
                end

                // Illegal code: drop request, go idle
                default: begin
                    mem_req <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // peripheral_dma_channel_regs

// >>> shared/periph_dma_defines.vh
`ifndef PERIPH_DMA_DEFINES_VH
`define PERIPH_DMA_DEFINES_VH

// Register byte offsets
`define OFS_RX_ADDRESS 8'h00
`define OFS_RX_COUNT 8'h04
`define OFS_TX_ADDRESS 8'h08
`define OFS_TX_COUNT 8'h0C
`define OFS_RX_NEXT_ADDRESS 8'h10
`define OFS_RX_NEXT_COUNT 8'h14
`define OFS_TX_NEXT_ADDRESS 8'h18
`define OFS_TX_NEXT_COUNT 8'h1C
`define OFS_TRANSFER_CONTROL 8'h20
`define OFS_TRANSFER_STATE 8'h24

// Control and state bit positions
`define BIT_RX_REQUEST_ENABLE 0
`define BIT_RX_REQUEST_DISABLE 1
`define BIT_TX_REQUEST_ENABLE 8
`define BIT_TX_REQUEST_DISABLE 9

// Field widths and reset values
`define COUNT_W 16
`define RST_ADDRESS 32'h0000_0000
`define RST_COUNT 16'h0000

// Transfer unit size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

`endif

// >>> tb/dma_regs_asserts.sv
`timescale 1ns/10ps
module dma_regs_checker (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic half_duplex, // Shared mode
    input wire logic rx_take, // Rx pulse
    input wire logic tx_load, // Tx pulse
    input wire logic [31:0] tx_hold_data, // Tx data
    input wire logic mem_req, // Memory request
    input wire logic mem_write, // Direction
    input wire logic [31:0] mem_addr, // Memory address
    input wire logic mem_ack, // Memory done
    input wire logic [31:0] mem_rdata, // Memory data
    input wire logic rx_active, // Rx enabled
    input wire logic tx_active // Tx enabled
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ctl_q;
    wire take = hsel && htrans[1] && hready;
    // Control write in its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ctl_q <= 1'b0;
        else if (hready) ctl_q <= take && hwrite && haddr == 32'h0000_0020;
    end
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_rx_en; ctl_q && hwdata[0] && !hwdata[1] && !(half_duplex && hwdata[9])
        |=> rx_active; endproperty
    a_rx_en: assert property (p_rx_en) else $error("rx not enabled");
    property p_rx_dis; ctl_q && (hwdata[1] || half_duplex && hwdata[9]) |=> !rx_active;
    endproperty
    a_rx_dis: assert property (p_rx_dis) else $error("rx not disabled");
    property p_tx_en; ctl_q && !half_duplex && hwdata[8] && !hwdata[9] |=> tx_active;
    endproperty
    a_tx_en: assert property (p_tx_en) else $error("tx not enabled");
    property p_tx_dis; ctl_q && (hwdata[9] || half_duplex && hwdata[1]) |=> !tx_active;
    endproperty
    a_tx_dis: assert property (p_tx_dis) else $error("tx not disabled");
    property p_hd_rx; ctl_q && half_duplex && hwdata[0] |=> !tx_active; endproperty
    a_hd_rx: assert property (p_hd_rx) else $error("tx left on by rx enable");
    property p_still; !ctl_q |=> $stable(rx_active) && $stable(tx_active); endproperty
    a_still: assert property (p_still) else $error("enable moved without write");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("request dropped early");
    property p_rx_done; mem_req && mem_ack && mem_write |=> rx_take && !mem_req; endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx unit not closed");
    property p_tx_done; mem_req && mem_ack && !mem_write
        |=> tx_load && tx_hold_data == $past(mem_rdata); endproperty
    a_tx_done: assert property (p_tx_done) else $error("tx unit wrong");
    property p_need_en; $rose(mem_req) |-> $past(rx_active) || $past(tx_active); endproperty
    a_need_en: assert property (p_need_en) else $error("request while disabled");
endmodule // dma_regs_checker
bind peripheral_dma_channel_regs dma_regs_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .half_duplex(half_duplex), .rx_take(rx_take),
    .tx_load(tx_load), .tx_hold_data(tx_hold_data), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_active(rx_active),
    .tx_active(tx_active));

// >>> tb/dma_far_side_model.sv
`timescale 1ns/10ps
module dma_far_side_model (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic rx_feed, // Keep rx data coming
    input wire logic tx_feed, // Keep tx space open
    input wire logic [3:0] lat, // Memory wait cycles
    input wire logic rx_take, // Rx unit taken
    input wire logic tx_load, // Tx unit loaded
    input wire logic mem_req, // Memory request
    input wire logic mem_write, // Direction
    input wire logic [31:0] mem_addr, // Memory address
    input wire logic [31:0] mem_wdata, // Write data
    output logic rx_ready, // Rx data present
    output logic [31:0] rx_hold_data, // Rx data
    output logic tx_ready, // Tx space present
    output logic mem_ack, // Memory done
    output logic [31:0] mem_rdata, // Read data
    output logic [15:0] wr_n, // Memory writes seen
    output logic [31:0] wr_addr, // Last write address
    output logic [31:0] wr_data // Last write data
);
    logic [3:0] wait_q;
    logic [15:0] rx_seq;
    // Data only valid with its qualifier, inverted otherwise
    assign rx_hold_data = rx_ready ? {16'hda7a, rx_seq} : ~{16'hda7a, rx_seq};
    assign mem_rdata = mem_ack ? ~mem_addr : mem_addr;
    // Ready drops after each unit; memory answers after lat cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rx_ready, tx_ready, mem_ack, wait_q, rx_seq, wr_n} <= '0;
            {wr_addr, wr_data} <= '0;
        end else begin
            rx_ready <= rx_feed && !rx_take;
            tx_ready <= tx_feed && !tx_load;
            if (rx_take) rx_seq <= rx_seq + 16'h0001;
            mem_ack <= mem_req && !mem_ack && wait_q == lat;
            wait_q <= (mem_req && !mem_ack && wait_q != lat) ? wait_q + 4'h1 : 4'h0;
            if (mem_req && mem_ack && mem_write) begin
                wr_n <= wr_n + 16'h0001;
                wr_addr <= mem_addr;
                wr_data <= mem_wdata;
            end
        end
    end
endmodule // dma_far_side_model

// >>> tb/peripheral_dma_channel_regs_tb_top.sv
`timescale 1ns/10ps
module peripheral_dma_channel_regs_tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, half_duplex = 0, rx_feed = 0, tx_feed = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, v, last_tx = 0;
    logic [1:0] htrans = 0, unit_size = 0, st = 0;
    logic [3:0] lat = 0;
    logic [15:0] tx_n = 0, wr_n;
    wire hreadyout, hresp, rx_take, tx_load, mem_req, mem_write, mem_ack, rx_ready, tx_ready;
    wire rx_active, tx_active;
    wire [31:0] hrdata, tx_hold_data, mem_addr, mem_wdata, mem_rdata, rx_hold_data;
    wire [31:0] wr_addr, wr_data;
    wire [1:0] mem_size;
    integer err_count = 0, checks = 0, seed = 44, i, k;
    always #25 hclk = ~hclk;
    // Capture each tx unit
    always @(posedge hclk) if (tx_load === 1'b1) begin
        last_tx <= tx_hold_data;
        tx_n <= tx_n + 16'h0001;
    end
    peripheral_dma_channel_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .half_duplex(half_duplex), .unit_size(unit_size), .rx_ready(rx_ready),
        .rx_hold_data(rx_hold_data), .tx_ready(tx_ready), .rx_take(rx_take),
        .tx_hold_data(tx_hold_data), .tx_load(tx_load), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_active(rx_active), .tx_active(tx_active));
    dma_far_side_model u_far (.hclk(hclk), .hresetn(hresetn), .rx_feed(rx_feed),
        .tx_feed(tx_feed), .lat(lat), .rx_take(rx_take), .tx_load(tx_load), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rx_ready(rx_ready),
        .rx_hold_data(rx_hold_data), .tx_ready(tx_ready), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .wr_n(wr_n), .wr_addr(wr_addr), .wr_data(wr_data));
    // Expected enables {tx, rx} after a control write
    function automatic logic [1:0] ctl_next(logic hd, logic [1:0] s, logic [31:0] w);
        if (!hd) return {w[9] ? 1'b0 : (w[8] | s[1]), w[1] ? 1'b0 : (w[0] | s[0])};
        if (w[1] || w[9]) return 2'b00;
        if (w[0]) return 2'b01;
        return w[8] ? {1'b1, s[0]} : s;
    endfunction
    task check(input string what, input logic [31:0] seen, exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task final_report;
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wait_ready;
        integer n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 20) begin @(posedge hclk); n = n + 1; end
        if (n >= 20) begin err_count = err_count + 1; final_report; end
    endtask
    task xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= a;
        wait_ready;
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask
    task rd_chk(input string what, input logic [31:0] a, exp);
        xfer(1'b0, a, 32'h0);
        check(what, rd, exp);
        check("resp", {31'h0, hresp}, 0);
    endtask
    task wait_cnt(input logic is_tx, input logic [15:0] n);
        k = 0;
        while ((is_tx ? tx_n : wr_n) !== n && k < 2000) begin @(posedge hclk); k = k + 1; end
        if (k >= 2000) begin err_count = err_count + 1; final_report; end
    endtask
    initial begin #4000000; err_count = err_count + 1; final_report; end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 11; i++) rd_chk("reset", (i == 10) ? 32'h100 : 4 * i, 0);
        for (k = 0; k < 2; k++) begin
            half_duplex <= k[0];
            for (i = 0; i < 8; i++) begin
                v = $random(seed);
                xfer(1'b1, 4 * i, v);
                rd_chk("shared", 4 * (i ^ k * 2), i[0] ? v & 32'hffff : v);
            end
        end
        rd_chk("control", 32'h20, 0);
        for (k = 0; k < 2; k++) begin
            half_duplex <= k[0];
            for (i = 0; i < 16; i++) begin
                v = $random(seed) & 32'h0000_0303;
                if (k == 1 && v[0]) v[8] = 1'b0;
                xfer(1'b1, 32'h20, v);
                st = ctl_next(k[0], st, v);
                rd_chk("state", 32'h24, {23'h0, st[1], 7'h0, st[0]});
                check("enables", {30'h0, tx_active, rx_active}, {30'h0, st});
            end
        end
        half_duplex <= 1'b0;
        xfer(1'b1, 32'h20, 32'h0000_0202);
        unit_size <= 2'h2;
        lat <= {2'b00, 2'($random(seed))};
        xfer(1'b1, 32'h00, 32'h0000_1000);
        xfer(1'b1, 32'h04, 32'h2);
        xfer(1'b1, 32'h10, 32'h0000_2000);
        xfer(1'b1, 32'h14, 32'h1);
        rx_feed <= 1'b1;
        xfer(1'b1, 32'h20, 32'h1);
        wait_cnt(1'b0, 16'h3);
        repeat (20) @(posedge hclk);
        check("rx units", wr_n, 3);
        check("rx addr", wr_addr, 32'h0000_2000);
        check("rx data", wr_data, 32'hda7a_0002);
        rd_chk("rx count", 32'h04, 0);
        rd_chk("rx next", 32'h14, 0);
        rd_chk("rx next addr", 32'h10, 0);
        rd_chk("rx addr", 32'h00, 32'h0000_2004);
        rx_feed <= 1'b0;
        // Random tx next count from the shared test would reload
        xfer(1'b1, 32'h1c, 32'h0);
        for (i = 0; i < 3; i++) begin
            unit_size <= i[1:0];
            lat <= {2'b00, 2'($random(seed))};
            xfer(1'b1, 32'h08, 32'h0000_3000);
            xfer(1'b1, 32'h0c, 32'h2);
            tx_feed <= 1'b1;
            xfer(1'b1, 32'h20, 32'h100);
            wait_cnt(1'b1, 2 * (i + 1));
            tx_feed <= 1'b0;
            check("tx data", last_tx, ~(32'h0000_3000 + (1 << i)));
            check("unit size", {30'h0, mem_size}, i);
            rd_chk("tx count", 32'h0c, 0);
            rd_chk("tx addr", 32'h08, 32'h0000_3000 + 2 * (1 << i));
        end
        final_report;
    end
endmodule // peripheral_dma_channel_regs_tb_top
